// File: verilog/dso_top.sv
// Drive status output logic with APB-mapped terminal selections
//
// Contract
// R1 - Codes 0-99 conduct, 100-199 invert
// R2 - One function may drive several terminals
// R3 - Undefined code leaves terminal without function
// R4 - Alarm select one routes alarm to four terminals
// R5 - Running terminal and alarm relay unaffected
// R6 - Fault-hold alarm drops when supply removed
// R7 - Encoder mode: first detectors use measured speed
// R8 - Ready off in alarm, inhibit, power failure
// R9 - Open loop: motion outputs at starting frequency
// R10 - Open loop: start output follows start command
// R11 - Start output on in DC brake, off stopped
// R12 - Sensorless primary motion off in brake/tuning/preexcite
// R13 - Sensorless secondary motion off on alarm/inhibit
// R14 - Zero-speed preexcite keeps secondary; request drops it
// R15 - Preexcite ready on during preexcite, off inhibited
// R16 - Request-driven preexcite ready delayed 100/500 ms
// R17 - Preexcite when start on and command zero
// R18 - Position control: secondary on while request held
// R19 - Function codes 11,33,0,44,45 plus inverted
// R20 - Running terminal defaults to primary motion
// R21 - Speed reached steady only with zero ramp
// R22 - Level is function XOR inversion, every cycle
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/100ps
`default_nettype none

// Status levels, terminal mapping and a small register map.
// Inputs are taken as synchronous to clock_i.
// Ready delays are counted in clock cycles, so they
// follow the clock rate set through the parameters.
// All outputs are registered: one cycle behind inputs.

module dso_top
  import dso_pkg::*;
#(
  parameter int DLY_CYC = DSO_DLY_CYC,             // Normal ready delay in cycles
  parameter int DLY_LARGE_CYC = DSO_DLY_LARGE_CYC  // Large-model ready delay
) (
  input wire logic clock_i,            // 100 MHz clock
  input wire logic rst_n_i,            // Async reset, active low
  input wire logic psel_i,             // APB select
  input wire logic penable_i,          // APB enable
  input wire logic pwrite_i,           // APB write
  input wire logic [7:0] paddr_i,      // APB byte address
  input wire logic [31:0] pwdata_i,    // APB write data
  output logic [31:0] prdata_o,        // APB read data
  output logic pready_o,               // APB ready
  output logic pslverr_o,              // APB error
  input wire dso_mode_t mode_i,        // Control mode
  input wire dso_state_t state_i,      // Drive operating state
  input wire dso_det_t det_i,          // Detector comparisons
  input wire logic [3:0] alarm_code_i, // Alarm code bits
  output logic [DSO_NUM_TERM-1:0] term_o, // Terminal conduct levels
  output logic drive_ready_o,          // Ready status
  output logic preexcite_ready_o,      // Pre-excitation ready status
  output logic motion_active_o,        // Primary motion status
  output logic motion_active_alt_flag_o, // Secondary motion status
  output logic start_command_flag_o    // Start command status
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Selections are flip-flops indexed by terminal.
  // The counter covers the long delay at full clock.

  logic [31:0] ctrl;                        // Control bits
  logic [7:0] tsel [DSO_NUM_TERM];          // terminal_function_select
  logic access;                             // APB access phase
  logic [2:0] tidx;                         // Selected terminal index
  logic tsel_hit;                           // Address falls on a selection
  logic alarm_code_output_select;           // Alarm routing select
  logic large_model;                        // Larger capacity delay
  logic [31:0] dly_cnt;                     // Pre-excite ready delay counter
  logic fault_hold_alarm;                   // Alarm held through reset
  logic speed_reached;                      // Chosen speed-reached source
  logic freq_detect_first;                  // Chosen first detect source
  logic freq_detect_second;                 // Second detect
  logic freq_detect_third;                  // Third detect
  logic power_loss_flag;                    // Power loss indication
  logic overload_flag;                      // Overload indication
  logic next_ready, next_pre_rdy, next_run, next_motion_active_alt_flag, next_start_command_flag;
  logic preexcite;                          // Pre-excitation in progress
  logic [DSO_NUM_TERM-1:0] alarm_route;     // Alarm code per terminal

  // Address decode for both paths.
  // The range test uses the full word index;
  // a cut index would fold high addresses
  // back onto the selection table.
  // Sub-word addresses are refused.
  assign access = psel_i && penable_i;
  assign tidx = 3'(paddr_i[7:2] - 6'd2);
  assign tsel_hit = (paddr_i[1:0] == 2'b00) && (paddr_i >= DSO_OFF_TSEL0)
                    && ((paddr_i[7:2] - DSO_OFF_TSEL0[7:2]) < 6'(DSO_NUM_TERM));
  // Code bits land on terminals 1 to 4 only
  assign alarm_route = {2'b00, alarm_code_i, 1'b0}; // R4
  assign alarm_code_output_select = ctrl[DSO_CTRL_ALMSEL_BIT];
  assign large_model = ctrl[DSO_CTRL_LARGE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, error on unmapped address
  // Setup is decoded and the answer is
  // registered, so it stands exactly in
  // the single access cycle.
  // Writes land at the end of access only.

  // Write path for control and selections
  // Control is stored whole; low bits used.
  // Reset puts primary motion on terminal 0.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl <= DSO_CTRL_RST;
      tsel[0] <= DSO_TSEL_RST0; // R20
      for (int i = 1; i < DSO_NUM_TERM; i++) begin
        tsel[i] <= DSO_TSEL_RSTN;
      end
    end else if (access && pwrite_i) begin
      if (paddr_i == DSO_OFF_CTRL) begin
        ctrl <= pwdata_i;
      end else if (tsel_hit) begin
        tsel[tidx] <= pwdata_i[7:0];
      end
    end
  end

  // Read path and answer; status register shows live outputs
  // Data clear outside access cycles, never stale.
  // Status is a setup-cycle snapshot.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i) begin
        if (paddr_i == DSO_OFF_CTRL) begin
          prdata_o <= {29'h0, ctrl[2:0]};
        end else if (paddr_i == DSO_OFF_STATUS) begin
          // Bit 12 spare keeps the hold flag at bit 13
          prdata_o <= {18'h0, fault_hold_alarm, 1'b0, term_o, drive_ready_o, preexcite_ready_o,
                       motion_active_o, motion_active_alt_flag_o, start_command_flag_o};
        end else if (tsel_hit) begin
          prdata_o <= {24'h0, tsel[tidx]};
        end else begin
          pslverr_o <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Detector source selection

  // Encoder feedback uses measured speed for the first two only
  // Position control shares that source.
  // Second and third follow output frequency.
  // Overload has no source yet; it reads low.
  always_comb begin
    if (mode_i == DSO_MODE_ENC || mode_i == DSO_MODE_POS) begin
      speed_reached = det_i.su_act;       // R7
      freq_detect_first = det_i.fu1_act;  // R7
    end else begin
      speed_reached = det_i.su_out;
      freq_detect_first = det_i.fu1_out;
    end
    // Ramp of zero hides any chatter from a moving setting
    // With a nonzero ramp the raw result passes.
    if (ctrl[DSO_CTRL_ACCZERO_BIT] && det_i.freq_varying) begin
      speed_reached = 1'b1; // R21
    end
    freq_detect_second = det_i.fu2; // R7
    freq_detect_third = det_i.fu3;  // R7
    power_loss_flag = state_i.power_fail;
    overload_flag = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status functions
  //
  // Levels are computed here and registered
  // once, so a status output and a terminal
  // with the same function move together.
  // A stop or inhibit ends pre-excitation.

  assign preexcite = state_i.start_cmd && state_i.freq_cmd_zero && !state_i.alarm
                     && !state_i.output_inhibit_input; // R17

  // Derive status levels from operating state and mode
  // Open-loop rules first; vector modes refine.
  // Restart overrides all but the pre-ready rule.
  always_comb begin
    // Power failure or undervoltage drops ready at once
    next_ready = !(state_i.alarm || state_i.output_inhibit_input || state_i.power_fail); // R8
    next_run = state_i.at_start_freq && state_i.running && !state_i.dc_brake; // R9
    next_start_command_flag = state_i.start_cmd; // R10 R11
    next_motion_active_alt_flag = next_run; // R9
    next_pre_rdy = 1'b0;
    // Vector modes also wait out tuning
    if (mode_i != DSO_MODE_VF) begin
      next_run = next_run && !state_i.tuning && !preexcite; // R12
      next_motion_active_alt_flag = state_i.start_cmd && !state_i.alarm && !state_i.output_inhibit_input
                  && !state_i.dc_brake && !state_i.coasting; // R13 R14
      // A request drops it; servo-on keeps it
      if (state_i.preexcite_request) begin
        next_motion_active_alt_flag = (mode_i == DSO_MODE_POS); // R14 R18
      end
      // DC braking counts as pre-excitation
      next_pre_rdy = (preexcite || state_i.dc_brake || state_i.preexcite_request)
                     && !state_i.output_inhibit_input && !state_i.alarm; // R15
      // A requested one waits for the delay
      if (state_i.preexcite_request && (dly_cnt != 32'd0)) begin
        next_pre_rdy = 1'b0; // R16
      end
    end
    // Restart rides through with all but pre-excitation ready on
    if (state_i.restarting) begin
      next_ready = 1'b1;
      next_run = 1'b1;
      next_motion_active_alt_flag = 1'b1;
      next_start_command_flag = 1'b1;
    end
  end

  // Delay counter reloads while the request is off
  // Counting starts on the first held cycle.
  // The size bit is read at reload only.
  // A held request stops at zero, no wrap.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dly_cnt <= 32'd1;
    end else if (!state_i.preexcite_request) begin
      dly_cnt <= large_model ? 32'(DLY_LARGE_CYC) : 32'(DLY_CYC); // R16
    end else if (dly_cnt != 32'd0) begin
      dly_cnt <= dly_cnt - 32'd1;
    end
  end

  // Alarm held until supply removed
  // Supply removal beats a live alarm, so
  // the flag falls as the supply goes.
  // Any later alarm sets it again.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_hold_alarm <= 1'b0;
    end else if (state_i.supply_off) begin
      fault_hold_alarm <= 1'b0; // R6
    end else if (state_i.alarm) begin
      fault_hold_alarm <= 1'b1;
    end
  end

  // Status outputs registered
  // Each output comes from a flip-flop.
  // Reset holds all low: nothing is ready.
  // One cycle of delay buys clean pins.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_ready_o <= 1'b0;
      preexcite_ready_o <= 1'b0;
      motion_active_o <= 1'b0;
      motion_active_alt_flag_o <= 1'b0;
      start_command_flag_o <= 1'b0;
    end else begin
      drive_ready_o <= next_ready;
      preexcite_ready_o <= next_pre_rdy;
      motion_active_o <= next_run;
      motion_active_alt_flag_o <= next_motion_active_alt_flag;
      start_command_flag_o <= next_start_command_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal drivers
  // Terminal 0 runs, terminal 6 is the relay.
  // Terminals 1 to 4 may carry the alarm code.

  // Look up a function level by its positive code
  // Returns {valid, level}; an unknown code
  // is invalid and keeps the terminal off.
  // Unregistered levels keep a terminal in
  // step with its status output.
  function automatic logic [1:0] fn_level(input logic [7:0] code);
    logic [1:0] r; // {valid, level}
    r = 2'b10;
    unique case (code)
      DSO_CODE_RUN: r[0] = next_run;           // R19
      DSO_CODE_SU: r[0] = speed_reached;
      DSO_CODE_IPF: r[0] = power_loss_flag;
      DSO_CODE_OL: r[0] = overload_flag;
      DSO_CODE_FU: r[0] = freq_detect_first;
      DSO_CODE_FU2: r[0] = freq_detect_second;
      DSO_CODE_FU3: r[0] = freq_detect_third;
      DSO_CODE_RDY: r[0] = next_ready;         // R19
      DSO_CODE_RDY2: r[0] = next_pre_rdy;      // R19
      DSO_CODE_MOTION_ACTIVE_ALT_FLAG: r[0] = next_motion_active_alt_flag;         // R19
      DSO_CODE_START_COMMAND_FLAG: r[0] = next_start_command_flag;         // R19
      DSO_CODE_FAULT_HOLD_ALARM: r[0] = fault_hold_alarm;
      DSO_CODE_ALM: r[0] = state_i.alarm;
      default: r = 2'b00;                      // R3
    endcase
    return r;
  endfunction : fn_level

  // Each terminal decodes its own selection independently
  // No terminal looks at another, so one
  // function may feed several at once.
  // The override comes after inversion.
  generate
    for (genvar t = 0; t < DSO_NUM_TERM; t++) begin : g_term // R2
      logic inv;
      logic [7:0] base;
      logic [1:0] lv;
      logic next_term;
      assign inv = (tsel[t] >= DSO_CODE_INV) && (tsel[t] <= DSO_CODE_MAX); // R1
      assign base = inv ? 8'(tsel[t] - DSO_CODE_INV) : tsel[t];
      // Looked up inside the process so a level
      // change wakes it while the code stands
      always_comb begin
        lv = (tsel[t] <= DSO_CODE_MAX) ? fn_level(base) : 2'b00; // R3
        next_term = lv[1] & (lv[0] ^ inv); // R22 R1
        // Terminals 1-4 carry alarm code; 0 and the relay keep theirs
        if (alarm_code_output_select && state_i.alarm && t >= 1 && t <= 4) begin
          next_term = alarm_route[t]; // R4 R5
        end
      end
      always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          term_o[t] <= 1'b0;
        end else begin
          term_o[t] <= next_term; // R22
        end
      end
    end
  endgenerate

endmodule : dso_top

`default_nettype wire

// File: verilog/dso_pkg.sv
// Package for the drive status output logic: offsets, codes and timing
package dso_pkg;

  // Register byte offsets on APB
  localparam logic [7:0] DSO_OFF_CTRL = 8'h00;
  localparam logic [7:0] DSO_OFF_STATUS = 8'h04;
  localparam logic [7:0] DSO_OFF_TSEL0 = 8'h08;
  localparam int DSO_NUM_TERM = 7;

  // Control register fields
  localparam int DSO_CTRL_ALMSEL_BIT = 0;
  localparam int DSO_CTRL_LARGE_BIT = 1;
  localparam int DSO_CTRL_ACCZERO_BIT = 2;
  localparam logic [31:0] DSO_CTRL_RST = 32'h0000_0000;

  // Function codes, positive logic; negative adds the inversion offset
  localparam logic [7:0] DSO_CODE_RUN = 8'h00;
  localparam logic [7:0] DSO_CODE_SU = 8'h01;
  localparam logic [7:0] DSO_CODE_IPF = 8'h02;
  localparam logic [7:0] DSO_CODE_OL = 8'h03;
  localparam logic [7:0] DSO_CODE_FU = 8'h04;
  localparam logic [7:0] DSO_CODE_FU2 = 8'h05;
  localparam logic [7:0] DSO_CODE_FU3 = 8'h06;
  localparam logic [7:0] DSO_CODE_RDY = 8'h0b;
  localparam logic [7:0] DSO_CODE_RDY2 = 8'h21;
  localparam logic [7:0] DSO_CODE_MOTION_ACTIVE_ALT_FLAG = 8'h2c;
  localparam logic [7:0] DSO_CODE_START_COMMAND_FLAG = 8'h2d;
  localparam logic [7:0] DSO_CODE_FAULT_HOLD_ALARM = 8'h5e;
  localparam logic [7:0] DSO_CODE_ALM = 8'h63;
  localparam logic [7:0] DSO_CODE_INV = 8'h64;
  localparam logic [7:0] DSO_CODE_MAX = 8'hc7;

  // Reset values of terminal selections: terminal 0 is the running terminal
  localparam logic [7:0] DSO_TSEL_RST0 = DSO_CODE_RUN;
  localparam logic [7:0] DSO_TSEL_RSTN = DSO_CODE_ALM;

  // Pre-excitation ready delay
  localparam int DSO_CLK_MHZ = 100;
  localparam int DSO_DLY_MS = 100;
  localparam int DSO_DLY_LARGE_MS = 500;
  localparam int DSO_DLY_CYC = DSO_DLY_MS * 1000 * DSO_CLK_MHZ;
  localparam int DSO_DLY_LARGE_CYC = DSO_DLY_LARGE_MS * 1000 * DSO_CLK_MHZ;

  // Control modes
  typedef enum logic [3:0] {
    DSO_MODE_VF = 4'h1,
    DSO_MODE_SLV = 4'h2,
    DSO_MODE_ENC = 4'h4,
    DSO_MODE_POS = 4'h8
  } dso_mode_t;

  // Drive operating state inputs
  typedef struct packed {
    logic start_cmd;          // Start command on
    logic running;            // Output active
    logic at_start_freq;      // Output freq at or above starting_frequency_setting
    logic freq_cmd_zero;      // Frequency command is 0 Hz
    logic dc_brake;           // DC injection braking
    logic tuning;             // Start-time tuning
    logic alarm;              // Protective function active
    logic output_inhibit_input; // Output shut off
    logic power_fail;         // Power failure or undervoltage
    logic coasting;           // Coasting after power failure
    logic restarting;         // Automatic restart
    logic preexcite_request;  // Pre-excitation input
    logic supply_off;         // Supply removed during power reset
  } dso_state_t;

  // Detector comparisons supplied by the speed logic
  typedef struct packed {
    logic su_out;    // Speed reached by output frequency
    logic su_act;    // Speed reached by measured speed
    logic fu1_out;   // First detect, output frequency
    logic fu1_act;   // First detect, measured speed
    logic fu2;       // Second detect
    logic fu3;       // Third detect
    logic freq_varying; // Frequency setting changing
  } dso_det_t;

endpackage : dso_pkg

// File: sim/dso_top_sva.sv
// Port-level assertion checker for the drive status output logic
`timescale 1ns/100ps
`default_nettype none

module dso_top_sva
  import dso_pkg::*;
#(
  parameter int DLY_CYC = DSO_DLY_CYC // Shortest pre-excitation ready delay
) (
  input wire logic clock_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pready_o, // APB ready
  input wire dso_mode_t mode_i, // Control mode
  input wire dso_state_t state_i, // Operating state
  input wire logic drive_ready_o, // Ready status
  input wire logic preexcite_ready_o, // Pre-excitation ready status
  input wire logic motion_active_o, // Primary motion status
  input wire logic motion_active_alt_flag_o, // Secondary motion status
  input wire logic start_command_flag_o // Start status
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // Restart forces all but pre-excitation ready on, so every off-rule excludes it
  wire logic restart = state_i.restarting;
  int req_cnt; // Cycles the request has been held, saturating

  //////////////////////////////////////////////////////////////////////////////
  // Count held request cycles; saturation keeps long holds from wrapping
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_cnt <= 0;
    end else if (!state_i.preexcite_request) begin
      req_cnt <= 0;
    end else if (req_cnt < DLY_CYC + 1) begin
      req_cnt <= req_cnt + 1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  property p_apb_answer;
    psel_i && !penable_i |=> pready_o;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("no answer in access cycle");
  property p_ready_off;
    (state_i.alarm || state_i.output_inhibit_input || state_i.power_fail) && !restart |=> !drive_ready_o;
  endproperty
  a_ready_off: assert property (p_ready_off) else $error("ready high while unable to run");
  property p_run_open;
    mode_i == DSO_MODE_VF && (!state_i.at_start_freq || state_i.dc_brake) && !restart |=> !motion_active_o;
  endproperty
  a_run_open: assert property (p_run_open) else $error("open-loop motion high below start");
  property p_start_on;
    mode_i == DSO_MODE_VF && state_i.start_cmd |=> start_command_flag_o;
  endproperty
  a_start_on: assert property (p_start_on) else $error("start status low with start on");
  property p_start_off;
    !state_i.start_cmd && !restart |=> !start_command_flag_o;
  endproperty
  a_start_off: assert property (p_start_off) else $error("start status high while stopped");
  property p_run_slv;
    mode_i == DSO_MODE_SLV && (state_i.dc_brake || state_i.tuning) && !restart |=> !motion_active_o;
  endproperty
  a_run_slv: assert property (p_run_slv) else $error("sensorless motion high in brake or tuning");
  property p_alt_slv;
    mode_i == DSO_MODE_SLV && (state_i.alarm || state_i.output_inhibit_input) && !restart
      |=> !motion_active_alt_flag_o;
  endproperty
  a_alt_slv: assert property (p_alt_slv) else $error("secondary motion high on fault");
  property p_pre_inh;
    state_i.output_inhibit_input && !restart |=> !preexcite_ready_o;
  endproperty
  a_pre_inh: assert property (p_pre_inh) else $error("pre-excitation ready while inhibited");
  property p_pre_dly;
    preexcite_ready_o && state_i.preexcite_request && !state_i.start_cmd |-> req_cnt >= DLY_CYC + 1;
  endproperty
  a_pre_dly: assert property (p_pre_dly) else $error("pre-excitation ready too early");
endmodule : dso_top_sva

bind dso_top dso_top_sva #(.DLY_CYC(DLY_CYC)) i_sva (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
  .penable_i(penable_i), .pready_o(pready_o), .mode_i(mode_i), .state_i(state_i), .drive_ready_o(drive_ready_o),
  .preexcite_ready_o(preexcite_ready_o), .motion_active_o(motion_active_o),
  .motion_active_alt_flag_o(motion_active_alt_flag_o), .start_command_flag_o(start_command_flag_o));

`default_nettype wire

// File: sim/dso_term_sense.sv
// Far-side model: external equipment sampling the output terminals
`timescale 1ns/100ps
`default_nettype none

module dso_term_sense
  import dso_pkg::*;
(
  input wire logic clock_i, // Controller clock
  input wire logic [DSO_NUM_TERM-1:0] term_i, // Terminal conduct levels
  output logic [DSO_NUM_TERM-1:0] seen_o // Levels as the equipment read them
);
  // Sample once a cycle, like an input card scanning its contacts
  always_ff @(posedge clock_i) begin
    seen_o <= term_i;
  end
endmodule : dso_term_sense

`default_nettype wire

// File: sim/dso_top_bench.sv
// Self-checking bench for the drive status output logic
`timescale 1ns/100ps
`default_nettype none

module dso_top_bench;
  import dso_pkg::*;
  localparam int DLY = 20; // Shortened ready delays keep the run brief
  localparam int DLY_L = 50;
  localparam logic [7:0] CODE [5] = '{DSO_CODE_RDY, DSO_CODE_RDY2, DSO_CODE_RUN, DSO_CODE_MOTION_ACTIVE_ALT_FLAG, DSO_CODE_START_COMMAND_FLAG};
  localparam logic [4:0] FN = 5'h1d; // Function states while running open loop
  logic clock_i = 1'b0; // Clock and reset
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0; // APB master side
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  dso_mode_t mode_i = DSO_MODE_VF; // Drive side
  dso_state_t state_i = '0;
  dso_det_t det_i = '0;
  logic [3:0] alarm_code_i = 4'h0;
  logic [6:0] term_o;
  logic [6:0] seen; // Terminal levels at the far side
  logic ready_s, pre_s, mot_s, alt_s, cmd_s; // Status outputs
  logic [31:0] rd; // Last read data and error
  logic er;
  int n_errors = 0;
  int cmp_count = 0;

  always #5 clock_i = ~clock_i;

  dso_top #(.DLY_CYC(DLY), .DLY_LARGE_CYC(DLY_L)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .mode_i(mode_i), .state_i(state_i), .det_i(det_i),
    .alarm_code_i(alarm_code_i), .term_o(term_o), .drive_ready_o(ready_s), .preexcite_ready_o(pre_s),
    .motion_active_o(mot_s), .motion_active_alt_flag_o(alt_s), .start_command_flag_o(cmd_s));
  dso_term_sense i_sense (.clock_i(clock_i), .term_i(term_o), .seen_o(seen));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  // One APB transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  // Apply a drive state and let status and far side settle
  task automatic put(input dso_mode_t m, input logic [12:0] s);
    @(posedge clock_i);
    mode_i <= m;
    state_i <= dso_state_t'(s);
    repeat (3) @(posedge clock_i);
  endtask : put

  // Compare {ready, motion, alt motion, start} under a mask
  task automatic row(input dso_mode_t m, input logic [12:0] s, input logic [3:0] e, input logic [3:0] k);
    put(m, s);
    chk("status", {ready_s, mot_s, alt_s, cmd_s} & k, e & k);
  endtask : row

  // Raise the request alone and count cycles until ready shows
  task automatic pre_dly(input int d);
    int n;
    n = 0;
    put(DSO_MODE_SLV, 13'h0000);
    state_i <= dso_state_t'(13'h0002);
    while (pre_s !== 1'b1 && n < 200) begin
      @(negedge clock_i);
      n++;
    end
    chk("pre_delay", n >= d && n <= d + 4, 1'b1);
  endtask : pre_dly

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs about three hundred cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    stop_test();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    apb(1'b0, DSO_OFF_TSEL0, 32'h0); chk("tsel0", rd, {24'h0, DSO_CODE_RUN});
    apb(1'b0, 8'h40, 32'h0); chk("unmapped", er, 1'b1);
    row(DSO_MODE_VF, 13'h0000, 4'h8, 4'hf);
    row(DSO_MODE_VF, 13'h1000, 4'h9, 4'hf);
    row(DSO_MODE_VF, 13'h1c00, 4'hf, 4'hf);
    row(DSO_MODE_VF, 13'h1100, 4'h9, 4'hf);
    row(DSO_MODE_VF, 13'h1040, 4'h1, 4'hf);
    row(DSO_MODE_VF, 13'h0020, 4'h0, 4'hf);
    row(DSO_MODE_VF, 13'h1018, 4'h1, 4'hf);
    row(DSO_MODE_VF, 13'h1804, 4'hf, 4'hf);
    row(DSO_MODE_SLV, 13'h1c00, 4'hf, 4'hf);
    row(DSO_MODE_SLV, 13'h1c80, 4'h8, 4'hc);
    row(DSO_MODE_SLV, 13'h1840, 4'h1, 4'hf);
    row(DSO_MODE_SLV, 13'h1200, 4'hb, 4'hf);
    row(DSO_MODE_SLV, 13'h1202, 4'h9, 4'hf);
    row(DSO_MODE_POS, 13'h1202, 4'h2, 4'h2);
    // Each code on three terminals, the middle one inverted
    put(DSO_MODE_VF, 13'h1c00);
    for (int i = 0; i < 5; i++) begin
      for (int t = 1; t < 4; t++) begin
        apb(1'b1, DSO_OFF_TSEL0 + 8'(4 * t), {24'h0, CODE[i] + (t == 2 ? 8'h64 : 8'h00)});
      end
      repeat (3) @(posedge clock_i);
      chk("terms", seen[3:0], {FN[i], ~FN[i], FN[i], 1'b1});
    end
    apb(1'b1, 8'h0c, 32'hc8);
    repeat (3) @(posedge clock_i);
    chk("undefined", seen[1], 1'b0);
    // Detectors: measured speed only for the first two under encoder
    apb(1'b1, 8'h0c, {24'h0, DSO_CODE_SU});
    apb(1'b1, 8'h10, {24'h0, DSO_CODE_FU});
    apb(1'b1, 8'h14, {24'h0, DSO_CODE_FU2});
    det_i <= dso_det_t'(7'h2c);
    put(DSO_MODE_ENC, 13'h1c00); chk("enc_det", seen[3:1], 3'h7);
    put(DSO_MODE_VF, 13'h1c00); chk("vf_det", seen[3:1], 3'h4);
    // Alarm code override on four terminals only
    for (int t = 1; t < 4; t++) begin
      apb(1'b1, DSO_OFF_TSEL0 + 8'(4 * t), {24'h0, DSO_CODE_ALM});
    end
    apb(1'b1, DSO_OFF_CTRL, 32'h1);
    put(DSO_MODE_VF, 13'h1040); chk("alm_code0", seen, 7'h60);
    alarm_code_i <= 4'hf;
    repeat (3) @(posedge clock_i);
    chk("alm_codef", seen, 7'h7e);
    put(DSO_MODE_VF, 13'h0000);
    apb(1'b0, DSO_OFF_STATUS, 32'h0); chk("hold_kept", rd[13], 1'b1);
    put(DSO_MODE_VF, 13'h0001);
    apb(1'b0, DSO_OFF_STATUS, 32'h0); chk("hold_drop", rd[13], 1'b0);
    apb(1'b1, DSO_OFF_CTRL, 32'h0);
    pre_dly(DLY);
    put(DSO_MODE_SLV, 13'h0022); chk("pre_inhibit", pre_s, 1'b0);
    apb(1'b1, DSO_OFF_CTRL, 32'h2);
    pre_dly(DLY_L);
    stop_test();
  end
endmodule : dso_top_bench

`default_nettype wire
